// File: src/cmar_top.sv
// Core memory address register: remote load and clear, local binary counting.
// Assumes external pins are synchronous to CLK and one AHB-Lite master.
//
// Operation
// - Start gate sets any of twelve bits whose address line is one.
// - Start gate needs pulse, counter zero, remote.
// - Counter zero means ready for new access.
// - Clear at end only in remote mode.
// - Normal clear acts asynchronously.
// - Single pulse select suppresses normal clear.
// - Single pulse clear at counter three, clocked.
// - Local mode counts 0000 to 7777 octal.
// - Low half bits 1-6, high 7-12.
// - Bit toggles when all lower bits one.
// - Low count enable false blocks low half.
// - Increment drive one microsecond gates counting.
// - High half counts only through its drive.
// - Shared carry terms for two and four bits.
// - Decode next count from delayed bit copies.
// - Self resetting delay flop updates copies.
// - Write driver only after read timing false.
// - High half counts on low carry or inhibit.
// - Manual step gives one clock increment.
`timescale 1ns/100ps
module cmar_top
  import cmar_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic                 HREADY,
  input  wire logic [31:0]          HWDATA,
  output logic [31:0]               HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  input  wire logic                 EXTERNAL_START_PULSE,
  input  wire logic [ADDR_BITS-1:0] INCOMING_ADDRESS_LINE,
  input  wire logic                 INFO_CLEAR_TIMING,
  input  wire logic                 READ_DRIVE_TIMING,
  input  wire logic                 WRITE_DRIVE_TIMING,
  input  wire logic                 STEP_REQUEST,
  output logic [ADDR_BITS-1:0]      CORE_ADDRESS_REGISTER,
  output logic [PC_BITS-1:0]        PULSE_COUNTER,
  output logic                      START_GATE,
  output logic                      INCREMENT_DRIVE,
  output logic                      READ_DRIVER_ENABLE,
  output logic                      WRITE_DRIVER_ENABLE
);

  cmar_ctrl_type          ctrl;
  logic [31:0]            status_word;
  logic [ADDR_BITS-1:0]   core_address;
  logic [HALF_BITS-1:0]   low_half_delayed_bit;
  logic [HALF_BITS-1:0]   high_half_delayed_bit;
  logic                   count_delay_flop;
  logic [PC_BITS-1:0]     pulse_counter;
  logic [7:0]             pc_timer;
  logic                   start_gate;
  logic                   normal_clear_drive;
  logic                   single_pulse_select;
  logic                   single_pulse_clear_drive;
  logic                   manual_step_increment;
  cmar_drive_type         drive_state;
  logic [7:0]             drive_count;
  logic                   increment_drive;
  logic                   counted;
  logic                   settled;
  logic                   count_go;
  logic                   low_count;
  logic                   high_half_count_drive;
  logic [HALF_BITS-1:0]   low_toggle;
  logic [HALF_BITS-1:0]   high_toggle;
  logic                   read_driver_enable;
  logic                   write_driver_enable;

  cmar_ahb_slave u_slave (
    .clk         (CLK),
    .reset_n     (RESET_N),
    .hsel        (HSEL),
    .haddr       (HADDR),
    .htrans      (HTRANS),
    .hwrite      (HWRITE),
    .hsize       (HSIZE),
    .hready      (HREADY),
    .hwdata      (HWDATA),
    .status_word (status_word),
    .hrdata      (HRDATA),
    .hreadyout   (HREADYOUT),
    .hresp       (HRESP),
    .ctrl        (ctrl)
  );

  cmar_step_sync u_step (
    .clk                   (CLK),
    .reset_n               (RESET_N),
    .step_request          (STEP_REQUEST),
    .local_mode            (~ctrl.remote_select),
    .manual_step_increment (manual_step_increment)
  );

  // Remote start and clear decodes.
  assign start_gate = EXTERNAL_START_PULSE & (pulse_counter == PC_IDLE)
                      & ctrl.remote_select;
  assign normal_clear_drive = INFO_CLEAR_TIMING & ctrl.remote_select
                              & ctrl.normal_clock_mode;
  assign single_pulse_select = ~ctrl.normal_clock_mode;
  assign single_pulse_clear_drive = ctrl.remote_select & single_pulse_select
                                    & (pulse_counter == PC_CLEAR);

  // Counting decode.
  assign increment_drive = (drive_state == DRIVE_ACTIVE);
  assign settled = ({high_half_delayed_bit, low_half_delayed_bit} == core_address);
  assign count_go = increment_drive & ~counted & settled & ~ctrl.remote_select;
  assign low_count = count_go & ctrl.low_half_count_enable;
  assign high_half_count_drive = count_go & ctrl.high_half_count_switch
                                 & (~ctrl.low_half_count_enable
                                    | (&low_half_delayed_bit));
  assign low_toggle  = cmar_half_toggle(low_count, low_half_delayed_bit);
  assign high_toggle = cmar_half_toggle(high_half_count_drive,
                                        high_half_delayed_bit);

  // Address register: clear wins, then load, then count.
  always_ff @(posedge CLK or posedge normal_clear_drive)
  begin
    if (normal_clear_drive)
      core_address <= '0;
    else if (!RESET_N)
      core_address <= '0;
    else if (single_pulse_clear_drive)
      core_address <= '0;
    else if (start_gate)
      core_address <= core_address | INCOMING_ADDRESS_LINE;
    else if (!ctrl.remote_select)
      core_address <= core_address ^ {high_toggle, low_toggle};
  end

  // Self resetting delay flop.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      count_delay_flop <= 1'b0;
    else
      count_delay_flop <= ~count_delay_flop;
  end

  // Delayed bit copies follow the register while the delay flop is set.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      low_half_delayed_bit  <= '0;
      high_half_delayed_bit <= '0;
    end
    else if (count_delay_flop)
    begin
      low_half_delayed_bit  <= core_address[HALF_BITS-1:0];
      high_half_delayed_bit <= core_address[ADDR_BITS-1:HALF_BITS];
    end
  end

  // Pulse counter: each state lasts one microsecond, started by the gate.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      pulse_counter <= PC_IDLE;
      pc_timer      <= 8'h00;
    end
    else if (pulse_counter != PC_IDLE || start_gate || pc_timer != 8'h00)
    begin
      if (pc_timer == 8'(PULSE_CYCLES - 1))
      begin
        pc_timer      <= 8'h00;
        pulse_counter <= pulse_counter + 2'h1;
      end
      else
        pc_timer <= pc_timer + 8'h01;
    end
  end

  // Increment drive stretches one step into a one microsecond drive.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      drive_state <= DRIVE_IDLE;
      drive_count <= 8'h00;
    end
    else
    begin
      case (drive_state)
        DRIVE_IDLE:
        begin
          drive_count <= 8'h00;
          if (manual_step_increment)
            drive_state <= DRIVE_ACTIVE;
        end
        DRIVE_ACTIVE:
        begin
          if (drive_count == 8'(PULSE_CYCLES - 1))
            drive_state <= DRIVE_IDLE;
          else
            drive_count <= drive_count + 8'h01;
        end
        default:
          drive_state <= DRIVE_IDLE;
      endcase
    end
  end

  // One count per drive.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      counted <= 1'b0;
    else if (!increment_drive)
      counted <= 1'b0;
    else if (count_go)
      counted <= 1'b1;
  end

  // Read and write current drivers never overlap.
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      read_driver_enable  <= 1'b0;
      write_driver_enable <= 1'b0;
    end
    else
    begin
      read_driver_enable  <= READ_DRIVE_TIMING;
      write_driver_enable <= WRITE_DRIVE_TIMING & ~READ_DRIVE_TIMING
                             & ~read_driver_enable;
    end
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_ADDR_POS +: ADDR_BITS] = core_address;
    status_word[STAT_PC_POS +: PC_BITS] = pulse_counter;
    status_word[STAT_GATE_POS] = start_gate;
    status_word[STAT_DELAY_POS] = count_delay_flop;
  end

  assign CORE_ADDRESS_REGISTER = core_address;
  assign PULSE_COUNTER         = pulse_counter;
  assign START_GATE            = start_gate;
  assign INCREMENT_DRIVE       = increment_drive;
  assign READ_DRIVER_ENABLE    = read_driver_enable;
  assign WRITE_DRIVER_ENABLE   = write_driver_enable;

  sequence s_step_begin;
    $rose(increment_drive);
  endsequence

  sequence s_step_counted;
    ##[0:3] count_go;
  endsequence

  chk_start_load_bits : assert property (@(posedge CLK) disable iff (!RESET_N)
    start_gate && !single_pulse_clear_drive |=> normal_clear_drive
      || (core_address & $past(INCOMING_ADDRESS_LINE)) == $past(INCOMING_ADDRESS_LINE))
    else $error("Start gate did not load address bits.");

  chk_gate_bounded : assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(start_gate) |-> ##[1:10] !start_gate)
    else $error("Start gate stood longer than one microsecond.");

  chk_gate_busy : assert property (@(posedge CLK) disable iff (!RESET_N)
    pulse_counter != PC_IDLE |-> !start_gate)
    else $error("Start gate opened during an operation.");

  chk_normal_clear : assert property (@(posedge CLK) disable iff (!RESET_N)
    INFO_CLEAR_TIMING && ctrl.remote_select && ctrl.normal_clock_mode
      |-> core_address == '0)
    else $error("Normal clear left address bits set.");

  chk_single_clear : assert property (@(posedge CLK) disable iff (!RESET_N)
    ctrl.remote_select && !ctrl.normal_clock_mode && pulse_counter == PC_CLEAR
      && !INFO_CLEAR_TIMING |=> core_address == '0 || start_gate)
    else $error("Single pulse clear missed at counter three.");

  chk_local_wrap : assert property (@(posedge CLK) disable iff (!RESET_N)
    count_go && core_address == 12'hFFF && ctrl.low_half_count_enable
      && ctrl.high_half_count_switch |=> core_address == 12'h000)
    else $error("Counter did not wrap to zero.");

  chk_local_plus_one : assert property (@(posedge CLK) disable iff (!RESET_N)
    count_go && ctrl.low_half_count_enable && ctrl.high_half_count_switch
      |=> core_address == $past(core_address) + 12'h001)
    else $error("Local count was not plus one.");

  chk_low_inhibit : assert property (@(posedge CLK) disable iff (!RESET_N)
    !ctrl.remote_select && !ctrl.low_half_count_enable
      && $past(!ctrl.low_half_count_enable) |=> $stable(core_address[HALF_BITS-1:0]))
    else $error("Low half counted while inhibited.");

  chk_one_count_per_step : assert property (@(posedge CLK) disable iff (!RESET_N)
    s_step_begin and !ctrl.remote_select |-> s_step_counted)
    else $error("Increment drive produced no count.");

  chk_write_after_read : assert property (@(posedge CLK) disable iff (!RESET_N)
    write_driver_enable |-> !read_driver_enable && !$past(READ_DRIVE_TIMING))
    else $error("Write driver overlapped read timing.");

  chk_delay_flop : assert property (@(posedge CLK) disable iff (!RESET_N)
    count_delay_flop |=> !count_delay_flop ##1 count_delay_flop)
    else $error("Delay flop did not reset itself.");

  chk_high_inhibit : assert property (@(posedge CLK) disable iff (!RESET_N)
    !ctrl.remote_select && !ctrl.high_half_count_switch
      |=> ctrl.remote_select || $stable(core_address[ADDR_BITS-1:HALF_BITS]))
    else $error("High half counted while its switch was off.");

  chk_step_drive_len : assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(increment_drive) |-> increment_drive [*8] ##1 increment_drive
      ##1 increment_drive ##1 !increment_drive)
    else $error("Increment drive did not last ten clocks.");

  chk_pc_step : assert property (@(posedge CLK) disable iff (!RESET_N)
    $changed(pulse_counter) |-> pulse_counter == $past(pulse_counter) + 2'h1)
    else $error("Pulse counter skipped a state.");

  chk_high_hold : assert property (@(posedge CLK) disable iff (!RESET_N)
    count_go && ctrl.low_half_count_enable && core_address[HALF_BITS-1:0] != 6'h3F
      |=> $stable(core_address[ADDR_BITS-1:HALF_BITS]))
    else $error("High half counted without a low carry.");

  chk_high_direct : assert property (@(posedge CLK) disable iff (!RESET_N)
    count_go && !ctrl.low_half_count_enable && ctrl.high_half_count_switch
      |=> core_address[ADDR_BITS-1:HALF_BITS]
          == $past(core_address[ADDR_BITS-1:HALF_BITS]) + 6'h01)
    else $error("High half did not count directly.");

endmodule // cmar_top

// File: src/cmar_pkg.sv
// Shared constants, register map, carrier types and count decode of the address register.
// Assumes a 10 MHz system clock and a single AHB-Lite master.
package cmar_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_TIME_NS = 1000;
  localparam int PULSE_CYCLES  = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_BITS = 12;
  localparam int HALF_BITS = 6;
  localparam int PC_BITS   = 2;

  localparam logic [1:0] PC_IDLE  = 2'h0;
  localparam logic [1:0] PC_CLEAR = 2'h3;

  localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;

  localparam int CTRL_REMOTE_POS   = 0;
  localparam int CTRL_NORMAL_POS   = 1;
  localparam int CTRL_LOW_CNT_POS  = 2;
  localparam int CTRL_HIGH_CNT_POS = 3;
  localparam logic [3:0] CTRL_RESET = 4'hF;

  localparam int STAT_ADDR_POS  = 0;
  localparam int STAT_PC_POS    = 12;
  localparam int STAT_GATE_POS  = 14;
  localparam int STAT_DELAY_POS = 15;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic high_half_count_switch;
    logic low_half_count_enable;
    logic normal_clock_mode;
    logic remote_select;
  } cmar_ctrl_type;

  typedef enum logic {
    DRIVE_IDLE,
    DRIVE_ACTIVE
  } cmar_drive_type;

  // Toggle mask of one six-bit half, built on the shared carry terms.
  function automatic logic [5:0] cmar_half_toggle(input logic drive, input logic [5:0] d);
    logic carry_two;
    logic carry_four;
    carry_two  = drive & d[0] & d[1];
    carry_four = carry_two & d[2] & d[3];
    cmar_half_toggle = {carry_four & d[4], carry_four, carry_two & d[2], carry_two,
                        drive & d[0], drive};
  endfunction

endpackage

// File: src/cmar_step_sync.sv
// Turns the manual step request level into a single clock pulse.
// Assumes the request is a slow level held for at least two clocks.
`timescale 1ns/100ps
module cmar_step_sync
  import cmar_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic step_request,
  input  wire logic local_mode,
  output logic      manual_step_increment
);

  logic req_meta;
  logic req_sync;
  logic req_last;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_last <= 1'b0;
    end
    else
    begin
      req_meta <= step_request;
      req_sync <= req_meta;
      req_last <= req_sync;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      manual_step_increment <= 1'b0;
    else
      manual_step_increment <= req_sync & ~req_last & local_mode;
  end

  chk_step_one_pulse : assert property (@(posedge clk) disable iff (!reset_n)
    manual_step_increment |=> !manual_step_increment)
    else $error("Manual step lasted more than one clock.");

endmodule // cmar_step_sync

// File: src/cmar_ahb_slave.sv
// AHB-Lite slave holding the control register and reading back block status.
// Assumes whole-word single transfers; answers with no wait state, always OKAY.
`timescale 1ns/100ps
module cmar_ahb_slave
  import cmar_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  input  wire logic [31:0]   status_word,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  output cmar_ctrl_type      ctrl
);

  logic        pend_write;
  logic [31:0] pend_addr;
  logic        take;

  assign take      = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pend_write <= 1'b0;
      pend_addr  <= 32'h0000_0000;
    end
    else
    begin
      pend_write <= take & hwrite;
      pend_addr  <= haddr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      hrdata <= 32'h0000_0000;
    else if (take & ~hwrite)
    begin
      if (haddr == CTRL_ADDR)
        hrdata <= {28'h000_0000, ctrl};
      else if (haddr == STATUS_ADDR)
        hrdata <= status_word;
      else
        hrdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ctrl <= cmar_ctrl_type'(CTRL_RESET);
    else if (pend_write && pend_addr == CTRL_ADDR)
    begin
      ctrl.remote_select          <= hwdata[CTRL_REMOTE_POS];
      ctrl.normal_clock_mode      <= hwdata[CTRL_NORMAL_POS];
      ctrl.low_half_count_enable  <= hwdata[CTRL_LOW_CNT_POS];
      ctrl.high_half_count_switch <= hwdata[CTRL_HIGH_CNT_POS];
    end
  end

  chk_zero_wait_okay : assert property (@(posedge clk) disable iff (!reset_n)
    take |=> (hreadyout && hresp == HRESP_OKAY))
    else $error("Slave did not answer with zero wait OKAY.");

endmodule // cmar_ahb_slave

// File: verif/cmar_requester.sv
// Requester model: one access with start pulse, address, drive timing and end clear.
// Assumes go is raised for one cycle while busy is low.
`timescale 1ns/100ps
module cmar_requester
  import cmar_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 go,
  input  wire logic [ADDR_BITS-1:0] addr,
  input  wire logic [5:0]           pulse_len,
  input  wire logic                 skip_clear,
  output logic                      busy,
  output logic [5:0]                phase,
  output logic                      start_pulse,
  output logic [ADDR_BITS-1:0]      address_lines,
  output logic                      info_clear,
  output logic                      read_timing,
  output logic                      write_timing
);
  logic [ADDR_BITS-1:0] held;
  logic                 no_clear;

  initial
  begin
    busy     = 1'b0;
    phase    = 6'h00;
    held     = '0;
    no_clear = 1'b0;
  end

  always @(posedge clk)
  begin
    if (go && !busy)
    begin
      busy     <= 1'b1;
      phase    <= 6'h00;
      held     <= addr;
      no_clear <= skip_clear;
    end
    else if (busy)
    begin
      phase <= phase + 6'h01;
      busy  <= (phase != 6'h2C);
    end
  end

  // Address lines show the inverse once the pulse is over.
  assign start_pulse   = busy && (phase < pulse_len);
  assign address_lines = start_pulse ? held : ~held;
  assign read_timing   = busy && (phase >= 6'h0A) && (phase < 6'h14);
  assign write_timing  = busy && (phase >= 6'h12) && (phase < 6'h1C);
  assign info_clear    = busy && !no_clear && ((phase == 6'h16) || (phase == 6'h17));
endmodule // cmar_requester

// File: verif/tb_top.sv
// Testbench of the address register with a reference model and an AHB-Lite master.
// Assumes the requester model stands on the remote side.
`timescale 1ns/100ps
module tb_top;
  import cmar_pkg::*;
  logic                 CLK, RESET_N, HSEL, HWRITE, STEP_REQUEST, go, skip_clear;
  logic [31:0]          HADDR, HWDATA, HRDATA, rd, seed;
  logic [1:0]           HTRANS, PULSE_COUNTER, pc_seen;
  logic                 HREADY, HREADYOUT, HRESP, START_GATE, INCREMENT_DRIVE;
  logic                 READ_DRIVER_ENABLE, WRITE_DRIVER_ENABLE, busy, start_pulse;
  logic                 info_clear, read_timing, write_timing, rt_seen;
  logic [ADDR_BITS-1:0] CORE_ADDRESS_REGISTER, addr, lines, model;
  logic [5:0]           phase, pulse_len;
  logic [3:0]           ctrl_sh;
  int                   n_errors, n_tests, we_cnt;

  assign HREADY = HREADYOUT;

  cmar_top uut (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXTERNAL_START_PULSE(start_pulse),
    .INCOMING_ADDRESS_LINE(lines), .INFO_CLEAR_TIMING(info_clear),
    .READ_DRIVE_TIMING(read_timing), .WRITE_DRIVE_TIMING(write_timing),
    .STEP_REQUEST(STEP_REQUEST), .CORE_ADDRESS_REGISTER(CORE_ADDRESS_REGISTER),
    .PULSE_COUNTER(PULSE_COUNTER), .START_GATE(START_GATE),
    .INCREMENT_DRIVE(INCREMENT_DRIVE), .READ_DRIVER_ENABLE(READ_DRIVER_ENABLE),
    .WRITE_DRIVER_ENABLE(WRITE_DRIVER_ENABLE));

  cmar_requester req (.clk(CLK), .go(go), .addr(addr), .pulse_len(pulse_len),
    .skip_clear(skip_clear), .busy(busy), .phase(phase), .start_pulse(start_pulse),
    .address_lines(lines), .info_clear(info_clear), .read_timing(read_timing),
    .write_timing(write_timing));

  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [11:0] next_count(input logic [11:0] a);
    logic [5:0] lo;
    logic [5:0] hi;
    logic       carry;
    lo    = a[5:0];
    hi    = a[11:6];
    carry = ctrl_sh[2] ? (lo == 6'h3F) : 1'b1;
    if (ctrl_sh[2])
      lo = lo + 6'h01;
    if (ctrl_sh[3] && carry)
      hi = hi + 6'h01;
    return {hi, lo};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if ((n_errors == 0) && (n_tests > 0))
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge CLK);
    HSEL   <= 1'b1;
    HADDR  <= a;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= wr;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    rd = HRDATA;
    check(HRESP, HRESP_OKAY);
  endtask

  task automatic set_ctrl(input logic [3:0] v);
    bus(1'b1, CTRL_ADDR, {28'h000_0000, v});
    ctrl_sh = v;
    bus(1'b0, CTRL_ADDR, 32'h0000_0000);
    check(rd, {28'h000_0000, v});
  endtask

  task automatic run_op(input logic [11:0] a, input logic [5:0] len, input logic skip);
    @(posedge CLK);
    go         <= 1'b1;
    addr       <= a;
    pulse_len  <= len;
    skip_clear <= skip;
    @(posedge CLK);
    go     <= 1'b0;
    we_cnt = 0;
    if (ctrl_sh[0])
      model = model | a;
    repeat (12) @(negedge CLK);
    check(CORE_ADDRESS_REGISTER, model);
    repeat (16) @(negedge CLK);
    if (ctrl_sh[0] && ctrl_sh[1] && !skip)
      model = 12'h000;
    check(CORE_ADDRESS_REGISTER, model);
    while (busy) @(negedge CLK);
    if (ctrl_sh[0] && !ctrl_sh[1])
      model = 12'h000;
    check(CORE_ADDRESS_REGISTER, model);
    check(we_cnt, 7);
  endtask

  task automatic step(input int n);
    int k;
    int hi;
    for (k = 0; k < n; k++)
    begin
      @(posedge CLK);
      STEP_REQUEST <= 1'b1;
      hi = 0;
      repeat (20)
      begin
        @(negedge CLK);
        hi += INCREMENT_DRIVE;
      end
      @(posedge CLK);
      STEP_REQUEST <= 1'b0;
      repeat (3) @(posedge CLK);
      if (!ctrl_sh[0])
        model = next_count(model);
      check(hi, ctrl_sh[0] ? 0 : 10);
      check(CORE_ADDRESS_REGISTER, model);
    end
  endtask

  task automatic do_reset;
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    ctrl_sh = 4'hF;
    model   = 12'h000;
  endtask

  always @(negedge CLK)
  begin
    if (RESET_N === 1'b1)
    begin
      check(START_GATE, start_pulse && (PULSE_COUNTER === PC_IDLE) && ctrl_sh[0]);
      if (info_clear && ctrl_sh[0] && ctrl_sh[1])
        check(CORE_ADDRESS_REGISTER, 12'h000);
      if (ctrl_sh[0] && !ctrl_sh[1] && (pc_seen === PC_CLEAR))
        check(CORE_ADDRESS_REGISTER, 12'h000);
      check(READ_DRIVER_ENABLE && WRITE_DRIVER_ENABLE, 1'b0);
      check(READ_DRIVER_ENABLE, rt_seen);
      if (busy && ctrl_sh[0] && (phase == 6'd15 || phase == 6'd25 || phase == 6'd35))
        check(PULSE_COUNTER, (phase - 6'd5) / 6'd10);
      we_cnt += WRITE_DRIVER_ENABLE;
    end
    pc_seen = PULSE_COUNTER;
    rt_seen = read_timing;
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    complete_run();
  end

  initial
  begin
    {HSEL, HWRITE, STEP_REQUEST, go, skip_clear} = 5'h00;
    {HADDR, HWDATA} = 64'h0;
    HTRANS    = 2'h0;
    addr      = 12'h000;
    pulse_len = 6'd10;
    RESET_N   = 1'b0;
    n_errors  = 0;
    n_tests   = 0;
    we_cnt    = 0;
    seed      = 32'hbf2d_229b;
    do_reset();
    bus(1'b0, CTRL_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    bus(1'b0, STATUS_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    repeat (3)
    begin
      seed = lfsr(seed);
      run_op(seed[11:0], 6'd10, 1'b0);
    end
    seed = lfsr(seed);
    run_op(seed[11:0], 6'd15, 1'b0);
    set_ctrl(4'hD);
    seed = lfsr(seed);
    run_op(seed[11:0], 6'd10, 1'b0);
    set_ctrl(4'hF);
    run_op(12'hFFF, 6'd10, 1'b1);
    step(1);
    set_ctrl(4'hE);
    step(1);
    seed = lfsr(seed);
    run_op(seed[11:0], 6'd10, 1'b0);
    step(70);
    set_ctrl(4'hA);
    step(3);
    set_ctrl(4'h6);
    step(2);
    bus(1'b0, STATUS_ADDR, 32'h0000_0000);
    check(rd[11:0], model);
    do_reset();
    check(CORE_ADDRESS_REGISTER, 12'h000);
    check(PULSE_COUNTER, PC_IDLE);
    check(INCREMENT_DRIVE, 1'b0);
    bus(1'b0, CTRL_ADDR, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    complete_run();
  end
endmodule // tb_top
